// >>> verilog/cmsb_pkg.sv
// cmsb_pkg.sv: constants for the call mode and stack bank select register
package cmsb_pkg;
	localparam logic [11:0] CMSB_REG_ADDR     = 12'hF84;
	localparam int          CMSB_MODE_BIT     = 3;
	localparam int          CMSB_ZERO_BIT     = 2;
	localparam logic [3:0]  CMSB_RESET_VAL    = 4'h8;
	localparam logic [1:0]  CMSB_BANK0        = 2'h0;
	localparam logic [1:0]  CMSB_BANK1        = 2'h1;
	localparam logic [1:0]  CMSB_PUSH_LEGACY  = 2'h2;
	localparam logic [1:0]  CMSB_PUSH_EXT     = 2'h3;
	localparam logic [2:0]  CMSB_CALL_LEGACY  = 3'h3;
	localparam logic [2:0]  CMSB_CALL_EXT     = 3'h4;
	localparam logic [2:0]  CMSB_FCALL_LEGACY = 3'h2;
	localparam logic [2:0]  CMSB_FCALL_EXT    = 3'h3;
	typedef enum logic [0:0] {
		CMSB_EXTENDED = 1'b0,
		CMSB_LEGACY   = 1'b1
	} cmsb_mode_t;
endpackage

// >>> verilog/cmsb_reg4.sv
// cmsb_reg4.sv: four-bit register cell with write strobe
`timescale 1ns/1ps
module cmsb_reg4
	import cmsb_pkg::*;
#(
	parameter logic [3:0] RESET_VAL = CMSB_RESET_VAL
) (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// write port
	input  wire logic       wr_in,
	input  wire logic [3:0] wdata_in,
	// stored value
	output logic      [3:0] q_out
);
	logic [3:0] val_q;
	logic [3:0] val_d;

	// next value: hold unless written
	always_comb begin
		val_d = wr_in ? wdata_in : val_q;
	end

	// storage
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			val_q <= RESET_VAL;
		end else begin
			val_q <= val_d;
		end
	end

	assign q_out = val_q;
endmodule

// >>> verilog/cmsb_top.sv
// cmsb_top.sv: call mode / stack bank register and derived cpu controls
`timescale 1ns/1ps
module cmsb_top
	import cmsb_pkg::*;
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// 4-bit memory access from the cpu
	input  wire logic [11:0] mem_addr_in,
	input  wire logic        mem_wr_in,
	input  wire logic        mem_rd_in,
	input  wire logic [3:0]  mem_wdata_in,
	output logic      [3:0]  mem_rdata_out,
	output logic             mem_hit_out,
	// decoded control to the cpu core
	output logic             call_mode_select_bit_out,
	output logic             stack_bank_out,
	output logic             stack_bank_bad_out,
	output logic      [1:0]  call_push_bytes_out,
	output logic      [2:0]  abs_call_cycles_out,
	output logic      [2:0]  fast_call_cycles_out,
	output logic             long_branch_en_out
);
	logic       sel;
	logic       wr_en;
	logic [3:0] reg_val;
	logic [3:0] rdata_d;
	logic [3:0] rdata_q;
	cmsb_mode_t mode;

	////////////////////////////////////////////////////////////////
	// address decode
	assign sel         = (mem_addr_in == CMSB_REG_ADDR);
	assign wr_en       = sel && mem_wr_in;
	assign mem_hit_out = sel && (mem_rd_in || mem_wr_in); // combinational handshake

	////////////////////////////////////////////////////////////////
	// storage; reset value puts legacy mode in force
	// reset to legacy
	cmsb_reg4 #(
		.RESET_VAL (CMSB_RESET_VAL)
	) u_reg (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.wr_in    (wr_en),
		.wdata_in (mem_wdata_in),
		.q_out    (reg_val)
	);

	////////////////////////////////////////////////////////////////
	// read data registered; full nibble returned as stored, so a
	// wrong bit 2 written by software stays visible for debugging
	always_comb begin
		rdata_d = (sel && mem_rd_in) ? reg_val : 4'h0;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rdata_q <= 4'h0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign mem_rdata_out = rdata_q;

	////////////////////////////////////////////////////////////////
	// mode decode; every call control follows the stored bit with no
	// extra stage, so a mode write is in force from the next cycle on
	// mode from bit3
	assign mode = cmsb_mode_t'(reg_val[CMSB_MODE_BIT]);
	assign call_mode_select_bit_out = reg_val[CMSB_MODE_BIT];

	assign call_push_bytes_out  = (mode == CMSB_LEGACY) ? CMSB_PUSH_LEGACY : CMSB_PUSH_EXT;
	assign abs_call_cycles_out  = (mode == CMSB_LEGACY) ? CMSB_CALL_LEGACY : CMSB_CALL_EXT;
	assign fast_call_cycles_out = (mode == CMSB_LEGACY) ? CMSB_FCALL_LEGACY : CMSB_FCALL_EXT;
	assign long_branch_en_out   = (mode == CMSB_EXTENDED);

	////////////////////////////////////////////////////////////////
	// stack bank; prohibited codes flagged, bank follows bit 0
	// field bits 1:0
	assign stack_bank_out     = reg_val[0];
	assign stack_bank_bad_out = (reg_val[1:0] != CMSB_BANK0) && (reg_val[1:0] != CMSB_BANK1);

	////////////////////////////////////////////////////////////////
	// assertions; each is disabled while reset is low unless it
	// checks the reset state itself
	property p_reset_legacy;
		@(posedge clk_in) !rst_n_in |=> call_mode_select_bit_out;
	endproperty
	a_reset_legacy: assert property (p_reset_legacy) else $error("mode not legacy after reset");

	property p_write_takes;
		@(posedge clk_in) disable iff (!rst_n_in)
		wr_en |=> call_mode_select_bit_out == $past(mem_wdata_in[3]);
	endproperty
	a_write_takes: assert property (p_write_takes) else $error("write not taken");

	property p_hold;
		@(posedge clk_in) disable iff (!rst_n_in)
		!wr_en |=> $stable(reg_val);
	endproperty
	a_hold: assert property (p_hold) else $error("register changed without write");

	property p_push;
		@(posedge clk_in) disable iff (!rst_n_in)
		call_push_bytes_out == (call_mode_select_bit_out ? 2'h2 : 2'h3);
	endproperty
	a_push: assert property (p_push) else $error("push count wrong");

	property p_long;
		@(posedge clk_in) disable iff (!rst_n_in)
		long_branch_en_out != call_mode_select_bit_out;
	endproperty
	a_long: assert property (p_long) else $error("long op enable wrong");

	property p_cycles;
		@(posedge clk_in) disable iff (!rst_n_in)
		abs_call_cycles_out == fast_call_cycles_out + 3'h1
		&& abs_call_cycles_out == (call_mode_select_bit_out ? 3'h3 : 3'h4);
	endproperty
	a_cycles: assert property (p_cycles) else $error("call cycles wrong");

	sequence s_ext_write;
		wr_en && !mem_wdata_in[3];
	endsequence
	property p_mode_ext;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_ext_write |=> !call_mode_select_bit_out && long_branch_en_out;
	endproperty
	a_mode_ext: assert property (p_mode_ext) else $error("extended mode not entered");

	property p_bank;
		@(posedge clk_in) disable iff (!rst_n_in)
		wr_en && mem_wdata_in[1:0] == 2'h1 |=> stack_bank_out && !stack_bank_bad_out;
	endproperty
	a_bank: assert property (p_bank) else $error("bank 1 not selected");

	property p_bad;
		@(posedge clk_in) disable iff (!rst_n_in)
		wr_en && mem_wdata_in[1] |=> stack_bank_bad_out;
	endproperty
	a_bad: assert property (p_bad) else $error("prohibited bank code not flagged");

	property p_read;
		@(posedge clk_in) disable iff (!rst_n_in)
		sel && mem_rd_in && !mem_wr_in |=> mem_rdata_out == $past(reg_val);
	endproperty
	a_read: assert property (p_read) else $error("read data wrong");

	////////////////////////////////////////////////////////////////
	// reset state beyond the mode bit: a call may push before any
	// write lands here, so the stack must already sit in bank 0
	property p_reset_bank;
		@(posedge clk_in) !rst_n_in |=> !stack_bank_out && !stack_bank_bad_out
			&& mem_rdata_out == 4'h0;
	endproperty
	a_reset_bank: assert property (p_reset_bank) else $error("reset state wrong");

	////////////////////////////////////////////////////////////////
	// decoded controls one cycle after a mode write; both directions
	// are checked so a decode stuck in one mode cannot slip through
	sequence s_legacy_write;
		wr_en && mem_wdata_in[CMSB_MODE_BIT];
	endsequence
	property p_legacy_counts;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_legacy_write |=> call_push_bytes_out == CMSB_PUSH_LEGACY
			&& abs_call_cycles_out == CMSB_CALL_LEGACY
			&& fast_call_cycles_out == CMSB_FCALL_LEGACY
			&& !long_branch_en_out;
	endproperty
	a_legacy_counts: assert property (p_legacy_counts) else $error("legacy controls wrong");

	property p_ext_counts;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_ext_write |=> call_push_bytes_out == CMSB_PUSH_EXT
			&& abs_call_cycles_out == CMSB_CALL_EXT
			&& fast_call_cycles_out == CMSB_FCALL_EXT;
	endproperty
	a_ext_counts: assert property (p_ext_counts) else $error("extended controls wrong");

	////////////////////////////////////////////////////////////////
	// storage keeps the whole nibble, bit 2 included, so a bad value
	// written by software can be read back rather than hidden
	property p_store_all;
		@(posedge clk_in) disable iff (!rst_n_in)
		wr_en |=> reg_val == $past(mem_wdata_in);
	endproperty
	a_store_all: assert property (p_store_all) else $error("nibble not stored");

	// legal bank 0 code clears both bank and fault flag
	property p_bank0;
		@(posedge clk_in) disable iff (!rst_n_in)
		wr_en && mem_wdata_in[1:0] == CMSB_BANK0 |=> !stack_bank_out && !stack_bank_bad_out;
	endproperty
	a_bank0: assert property (p_bank0) else $error("bank 0 not selected");

	////////////////////////////////////////////////////////////////
	// read port quiet between reads, so a stale nibble cannot be
	// mistaken for the answer to a later read
	property p_rdata_idle;
		@(posedge clk_in) disable iff (!rst_n_in)
		!(sel && mem_rd_in) |=> mem_rdata_out == 4'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");

	////////////////////////////////////////////////////////////////
	// write, one idle cycle, then read back: the read must return the
	// nibble just written, not the value from before the write
	sequence s_write_gap;
		wr_en ##1 !wr_en;
	endsequence
	sequence s_read_only;
		sel && mem_rd_in && !mem_wr_in;
	endsequence
	property p_readback;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_write_gap ##1 s_read_only |=> mem_rdata_out == $past(mem_wdata_in, 3);
	endproperty
	a_readback: assert property (p_readback) else $error("read back differs");
endmodule

// >>> tb/cmsb_test.sv
// cmsb_test.sv: self-checking bench for the call mode / stack bank register
`timescale 1ns/1ps
module cmsb_test
	import cmsb_pkg::*;
;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [11:0] addr = 12'h000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [3:0]  wd = 4'h0;
	logic [3:0]  rdata;
	logic        hit, mode, bank, bad, lng;
	logic [1:0]  push;
	logic [2:0]  acyc, fcyc;
	int          err_count = 0;
	int          comparisons = 0;
	int          cyc = 0;

	cmsb_top i_cmsb_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .mem_addr_in(addr),
		.mem_wr_in(wr), .mem_rd_in(rd), .mem_wdata_in(wd), .mem_rdata_out(rdata),
		.mem_hit_out(hit), .call_mode_select_bit_out(mode), .stack_bank_out(bank),
		.stack_bank_bad_out(bad), .call_push_bytes_out(push),
		.abs_call_cycles_out(acyc), .fast_call_cycles_out(fcyc),
		.long_branch_en_out(lng));

	////////////////////////////////////////////////////////////////////////////
	// 125 MHz clock
	always #4 clk_in = ~clk_in;

	// hang guard, far above the few dozen cycles the tests need
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 500) begin
			err_count = err_count + 1;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// write strobe held across the sampling edge, released at the next fall
	task automatic wr_reg(input logic [11:0] a, input logic [3:0] d);
		@(negedge clk_in);
		addr = a;
		wd = d;
		wr = 1'b1;
		#1 chk({3'h0, hit}, {3'h0, a == CMSB_REG_ADDR});
		@(negedge clk_in);
		wr = 1'b0;
	endtask

	// read data is registered: valid for one cycle, then back to zero
	task automatic rd_reg(input logic [11:0] a, input logic [3:0] exp);
		@(negedge clk_in);
		addr = a;
		rd = 1'b1;
		#1 chk({3'h0, hit}, {3'h0, a == CMSB_REG_ADDR});
		@(negedge clk_in);
		rd = 1'b0;
		chk(rdata, exp);
		@(negedge clk_in);
		chk(rdata, 4'h0);
	endtask

	// every decoded control against the mode bit and stack field
	task automatic chk_mode(input logic m, input logic [1:0] b);
		chk({3'h0, mode}, {3'h0, m});
		chk({2'h0, push}, {2'h0, m ? CMSB_PUSH_LEGACY : CMSB_PUSH_EXT});
		chk({1'h0, acyc}, {1'h0, m ? CMSB_CALL_LEGACY : CMSB_CALL_EXT});
		chk({1'h0, fcyc}, {1'h0, m ? CMSB_FCALL_LEGACY : CMSB_FCALL_EXT});
		chk({3'h0, lng}, {3'h0, ~m});
		chk({3'h0, bank}, {3'h0, b[0]});
		chk({3'h0, bad}, {3'h0, b[1]});
	endtask

	task automatic give_verdict();
		$display("comparisons=%0d mismatches=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (2) @(negedge clk_in);
		rst_n_in = 1'b1;
		chk_mode(1'b1, 2'h0);
		rd_reg(CMSB_REG_ADDR, CMSB_RESET_VAL);
		$display("reset test done");
		// both modes with both legal banks, back to back
		for (int i = 0; i < 4; i++) begin
			wr_reg(CMSB_REG_ADDR, {i[1], 2'b00, i[0]});
			chk_mode(i[1], {1'b0, i[0]});
			rd_reg(CMSB_REG_ADDR, {i[1], 2'b00, i[0]});
		end
		$display("mode test done");
		wr_reg(CMSB_REG_ADDR, 4'h2);
		chk_mode(1'b0, 2'h2);
		wr_reg(12'hF85, 4'h9);
		chk_mode(1'b0, 2'h2);
		rd_reg(12'hF85, 4'h0);
		$display("refusal test done");
		// reset again in mid-run
		@(negedge clk_in);
		rst_n_in = 1'b0;
		@(negedge clk_in);
		rst_n_in = 1'b1;
		chk_mode(1'b1, 2'h0);
		rd_reg(CMSB_REG_ADDR, CMSB_RESET_VAL);
		$display("second reset test done");
		give_verdict();
	end
endmodule
